// [tpc_ctrl.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module tpc_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // timer side
    input wire logic narrow_timer_output,
    input wire logic wide_timer_output,
    output logic [7:0] eight_bit_timer_ctrl,
    output logic [7:0] sixteen_bit_timer_ctrl,
    output logic wide_init_level,
    output logic narrow_init_level,
    output logic [1:0] tx_out_mode,
    output logic demod_mode,
    output logic demod_edge,
    // pins
    input wire logic port3_bit6_data,
    input wire logic port3_bit1,
    input wire logic port2_bit0,
    output logic port3_bit6
);

    typedef struct packed {
        logic sync_a1;
        logic sync_a2;
        logic sync_b1;
        logic sync_b2;
        logic filt_prev;
        logic [7:0] narrow_ctrl;
        logic [7:0] wide_ctrl;
        logic wide_init;
        logic narrow_init;
        logic fall_flag;
        logic rise_flag;
        logic [1:0] out_mode;
        logic [1:0] logic_sel;
        logic pin_sel;
        logic demod;
        logic [7:0] rdata;
        logic pin_out;
        logic edge_pulse;
    } tpc_ctrl_s;

    tpc_ctrl_s state_reg;
    tpc_ctrl_s state_next;
    logic filt_in;
    logic filt_q;
    logic det_rise;
    logic det_fall;
    logic wide_eff;
    logic combined;
    logic wr_shared;

    assign filt_in = state_reg.pin_sel ? state_reg.sync_b2
                                       : state_reg.sync_a2;

    tpc_glitch_filter #(
        .SHORT_CYC(tpc_pkg::FILT_SHORT_CYC),
        .LONG_CYC(tpc_pkg::FILT_LONG_CYC)
    ) u_filter (
        .clk(clk),
        .rst_b(rst_b),
        .din(filt_in),
        .sel(state_reg.out_mode),
        .dout(filt_q)
    );

    always_comb
    begin
        state_next = state_reg;
        state_next.sync_a1 = port3_bit1;
        state_next.sync_a2 = state_reg.sync_a1;
        state_next.sync_b1 = port2_bit0;
        state_next.sync_b2 = state_reg.sync_b1;
        state_next.filt_prev = filt_q;

        // edge selection, reserved code detects nothing
        det_rise = state_reg.demod && filt_q && !state_reg.filt_prev
            && (state_reg.logic_sel == tpc_pkg::EDGE_RISE
            || state_reg.logic_sel == tpc_pkg::EDGE_BOTH);
        det_fall = state_reg.demod && !filt_q && state_reg.filt_prev
            && (state_reg.logic_sel == tpc_pkg::EDGE_FALL
            || state_reg.logic_sel == tpc_pkg::EDGE_BOTH);
        state_next.edge_pulse = det_rise || det_fall;

        wr_shared = reg_wr && reg_addr == tpc_pkg::OFF_SHARED_CTRL;
        if (reg_wr && reg_addr == tpc_pkg::OFF_NARROW_CTRL)
            state_next.narrow_ctrl = reg_wdata;
        if (reg_wr && reg_addr == tpc_pkg::OFF_WIDE_CTRL)
            state_next.wide_ctrl = reg_wdata;
        if (wr_shared)
        begin
            if (state_reg.demod)
            begin
                if (reg_wdata[tpc_pkg::BIT_WIDE_INIT])
                    state_next.fall_flag = 1'b0;
                if (reg_wdata[tpc_pkg::BIT_NARROW_INIT])
                    state_next.rise_flag = 1'b0;
            end
            else
            begin
                state_next.wide_init = reg_wdata[tpc_pkg::BIT_WIDE_INIT];
                state_next.narrow_init =
                    reg_wdata[tpc_pkg::BIT_NARROW_INIT];
            end
            state_next.out_mode =
                reg_wdata[tpc_pkg::FLD_OUTMODE_LO +: 2];
            state_next.logic_sel = reg_wdata[tpc_pkg::FLD_LOGIC_LO +: 2];
            state_next.pin_sel = reg_wdata[tpc_pkg::BIT_PIN_SEL];
            state_next.demod = reg_wdata[tpc_pkg::BIT_DEMOD];
        end
        // falling flag set, set wins over clear
        if (det_fall)
            state_next.fall_flag = 1'b1;
        // rising flag set, set wins over clear
        if (det_rise)
            state_next.rise_flag = 1'b1;

        state_next.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                tpc_pkg::OFF_NARROW_CTRL:
                    state_next.rdata = state_reg.narrow_ctrl;
                tpc_pkg::OFF_WIDE_CTRL:
                    state_next.rdata = state_reg.wide_ctrl;
                tpc_pkg::OFF_SHARED_CTRL:
                begin
                    state_next.rdata[tpc_pkg::BIT_WIDE_INIT] =
                        state_reg.demod ? state_reg.fall_flag
                                        : state_reg.wide_init;
                    state_next.rdata[tpc_pkg::BIT_NARROW_INIT] =
                        state_reg.demod ? state_reg.rise_flag
                                        : state_reg.narrow_init;
                    state_next.rdata[tpc_pkg::FLD_OUTMODE_LO +: 2] =
                        state_reg.out_mode;
                    state_next.rdata[tpc_pkg::FLD_LOGIC_LO +: 2] =
                        state_reg.logic_sel;
                    state_next.rdata[tpc_pkg::BIT_PIN_SEL] =
                        state_reg.pin_sel;
                    state_next.rdata[tpc_pkg::BIT_DEMOD] = state_reg.demod;
                end
                default:
                    state_next.rdata = '0;
            endcase
        end

        case (state_reg.out_mode)
            tpc_pkg::OUT_FORCE_LO: wide_eff = 1'b0;
            tpc_pkg::OUT_FORCE_HI: wide_eff = 1'b1;
            default: wide_eff = wide_timer_output;
        endcase
        case (state_reg.logic_sel)
            tpc_pkg::LOGIC_AND: combined = narrow_timer_output & wide_eff;
            tpc_pkg::LOGIC_OR: combined = narrow_timer_output | wide_eff;
            tpc_pkg::LOGIC_NOR:
                combined = ~(narrow_timer_output | wide_eff);
            default: combined = ~(narrow_timer_output & wide_eff);
        endcase
        if (!state_reg.demod && state_reg.pin_sel)
            state_next.pin_out = combined;
        else
            state_next.pin_out = port3_bit6_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
            state_reg.narrow_ctrl <= tpc_pkg::RST_NARROW_CTRL;
            state_reg.wide_ctrl <= tpc_pkg::RST_WIDE_CTRL;
            state_reg.wide_init <=
                tpc_pkg::RST_SHARED_CTRL[tpc_pkg::BIT_WIDE_INIT];
            state_reg.narrow_init <=
                tpc_pkg::RST_SHARED_CTRL[tpc_pkg::BIT_NARROW_INIT];
            state_reg.out_mode <=
                tpc_pkg::RST_SHARED_CTRL[tpc_pkg::FLD_OUTMODE_LO +: 2];
            state_reg.logic_sel <=
                tpc_pkg::RST_SHARED_CTRL[tpc_pkg::FLD_LOGIC_LO +: 2];
            state_reg.pin_sel <=
                tpc_pkg::RST_SHARED_CTRL[tpc_pkg::BIT_PIN_SEL];
            state_reg.demod <= tpc_pkg::RST_SHARED_CTRL[tpc_pkg::BIT_DEMOD];
        end
        else
            state_reg <= state_next;
    end

    assign reg_rdata = state_reg.rdata;
    assign eight_bit_timer_ctrl = state_reg.narrow_ctrl;
    assign sixteen_bit_timer_ctrl = state_reg.wide_ctrl;
    assign wide_init_level = state_reg.wide_init;
    assign narrow_init_level = state_reg.narrow_init;
    assign tx_out_mode = state_reg.out_mode;
    assign demod_mode = state_reg.demod;
    assign demod_edge = state_reg.edge_pulse;
    assign port3_bit6 = state_reg.pin_out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_wide_init_read: assert property (
        reg_rd && reg_addr == tpc_pkg::OFF_SHARED_CTRL && !demod_mode
        |=> reg_rdata[tpc_pkg::BIT_WIDE_INIT] == $past(wide_init_level))
        else $error("transmit read of wide start level wrong");

    a_fall_flag_read: assert property (
        reg_rd && reg_addr == tpc_pkg::OFF_SHARED_CTRL && demod_mode
        |=> reg_rdata[tpc_pkg::BIT_WIDE_INIT]
        == $past(state_reg.fall_flag))
        else $error("demod read of falling flag wrong");

    a_fall_flag_clear: assert property (
        wr_shared && demod_mode && !det_fall
        |=> state_reg.fall_flag == ($past(state_reg.fall_flag)
        && !$past(reg_wdata[tpc_pkg::BIT_WIDE_INIT])))
        else $error("falling flag write effect wrong");

    a_narrow_init_write: assert property (
        wr_shared && !demod_mode
        |=> narrow_init_level == $past(reg_wdata[tpc_pkg::BIT_NARROW_INIT]))
        else $error("narrow start level not stored");

    a_rise_flag_clear: assert property (
        wr_shared && demod_mode && !det_rise
        |=> state_reg.rise_flag == ($past(state_reg.rise_flag)
        && !$past(reg_wdata[tpc_pkg::BIT_NARROW_INIT])))
        else $error("rising flag write effect wrong");

    a_force_low_out: assert property (
        !demod_mode && state_reg.pin_sel
        && tx_out_mode == tpc_pkg::OUT_FORCE_LO
        && state_reg.logic_sel == tpc_pkg::LOGIC_NOR
        |=> port3_bit6 == !$past(narrow_timer_output))
        else $error("forced low wide output not applied");

    a_combine_or_out: assert property (
        !demod_mode && state_reg.pin_sel
        && tx_out_mode == tpc_pkg::OUT_NORMAL
        && state_reg.logic_sel == tpc_pkg::LOGIC_OR
        |=> port3_bit6
        == $past(narrow_timer_output || wide_timer_output))
        else $error("OR combination wrong");

    a_rise_only_edges: assert property (
        demod_mode && state_reg.logic_sel == tpc_pkg::EDGE_RISE
        && !state_reg.fall_flag
        |=> !state_reg.fall_flag)
        else $error("falling edge flagged in rising-only mode");

    a_port_route_out: assert property (
        !demod_mode && !state_reg.pin_sel
        |=> port3_bit6 == $past(port3_bit6_data))
        else $error("port output not routed to pin");

    a_mode_after_reset: assert property (
        $rose(rst_b) |-> !demod_mode && !state_reg.pin_sel)
        else $error("mode not transmit after reset");

    c_fall_flag_set: cover property (
        demod_mode && !state_reg.fall_flag ##1 state_reg.fall_flag);
    c_rise_flag_set: cover property (
        demod_mode && !state_reg.rise_flag ##1 state_reg.rise_flag);
    c_force_high: cover property (
        !demod_mode && state_reg.pin_sel
        && tx_out_mode == tpc_pkg::OUT_FORCE_HI);
    c_flag_clear: cover property (
        wr_shared && demod_mode && state_reg.fall_flag);

endmodule

// [tpc_pkg.sv]
package tpc_pkg;

    // register offsets
    localparam logic [1:0] OFF_NARROW_CTRL = 2'h0;
    localparam logic [1:0] OFF_SHARED_CTRL = 2'h1;
    localparam logic [1:0] OFF_WIDE_CTRL = 2'h2;

    // reset values
    localparam logic [7:0] RST_NARROW_CTRL = 8'h00;
    localparam logic [7:0] RST_SHARED_CTRL = 8'h00;
    localparam logic [7:0] RST_WIDE_CTRL = 8'h00;

    // shared control field positions
    localparam int BIT_WIDE_INIT = 7;
    localparam int BIT_NARROW_INIT = 6;
    localparam int FLD_OUTMODE_LO = 4;
    localparam int FLD_LOGIC_LO = 2;
    localparam int BIT_PIN_SEL = 1;
    localparam int BIT_DEMOD = 0;

    // transmit output modes
    localparam logic [1:0] OUT_NORMAL = 2'h0;
    localparam logic [1:0] OUT_PING_PONG = 2'h1;
    localparam logic [1:0] OUT_FORCE_LO = 2'h2;
    localparam logic [1:0] OUT_FORCE_HI = 2'h3;

    // combining logic codes
    localparam logic [1:0] LOGIC_AND = 2'h0;
    localparam logic [1:0] LOGIC_OR = 2'h1;
    localparam logic [1:0] LOGIC_NOR = 2'h2;
    localparam logic [1:0] LOGIC_NAND = 2'h3;

    // demodulation filter codes
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_SHORT = 2'h1;
    localparam logic [1:0] FILT_LONG = 2'h2;
    localparam logic [1:0] FILT_RSVD = 2'h3;

    // demodulation edge codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_RSVD = 2'h3;

    // filter lengths in clock cycles
    localparam int FILT_SHORT_CYC = 4;
    localparam int FILT_LONG_CYC = 8;

endpackage

// [tpc_glitch_filter.sv]
`timescale 1ns/1ps
module tpc_glitch_filter #(
    parameter int SHORT_CYC = tpc_pkg::FILT_SHORT_CYC,
    parameter int LONG_CYC = tpc_pkg::FILT_LONG_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // filter
    input wire logic din,
    input wire logic [1:0] sel,
    output logic dout
);

    localparam int CW = $clog2(LONG_CYC);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic out;
    } tpc_filt_s;

    tpc_filt_s state_reg;
    tpc_filt_s state_next;
    logic [CW-1:0] limit;

    if (SHORT_CYC < 2 || LONG_CYC <= SHORT_CYC)
    begin : g_bad_len
        $error("filter lengths out of range");
    end

    always_comb
    begin
        state_next = state_reg;
        if (sel == tpc_pkg::FILT_SHORT)
            limit = CW'(SHORT_CYC - 1);
        else
            limit = CW'(LONG_CYC - 1);
        if (sel == tpc_pkg::FILT_NONE || sel == tpc_pkg::FILT_RSVD)
        begin
            state_next.out = din;
            state_next.cnt = '0;
        end
        else if (din == state_reg.out)
            state_next.cnt = '0;
        else if (state_reg.cnt == limit)
        begin
            state_next.out = din;
            state_next.cnt = '0;
        end
        else
            state_next.cnt = state_reg.cnt + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign dout = state_reg.out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_short_pulse_reject: assert property (
        $past(sel) == tpc_pkg::FILT_SHORT && sel == tpc_pkg::FILT_SHORT
        && $changed(dout)
        |-> $past(din, 1) == dout && $past(din, 2) == dout
        && $past(din, 3) == dout && $past(din, 4) == dout)
        else $error("short filter passed a pulse under four cycles");

    a_long_pulse_reject: assert property (
        $past(sel) == tpc_pkg::FILT_LONG && sel == tpc_pkg::FILT_LONG
        && $changed(dout)
        |-> $past(din, 1) == dout && $past(din, 4) == dout
        && $past(din, 8) == dout)
        else $error("long filter passed a pulse under eight cycles");

endmodule

// [tpc_pin_src.sv]
`timescale 1ns/1ps
module tpc_pin_src (
    // clock
    input wire logic clk,
    // source pins, driven low between pulses
    output logic port3_bit1,
    output logic port2_bit0
);
    initial
    begin
        port3_bit1 = 1'b0;
        port2_bit0 = 1'b0;
    end
    // one high pulse of w cycles on the chosen pin
    task automatic pulse(input logic pin, input int w);
        @(posedge clk);
        if (pin)
            port2_bit0 <= 1'b1;
        else
            port3_bit1 <= 1'b1;
        repeat (w) @(posedge clk);
        port3_bit1 <= 1'b0;
        port2_bit0 <= 1'b0;
    endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic n_out = 1'b0;
    logic w_out = 1'b0;
    logic port3_bit6_data = 1'b0;
    logic wide_init_level, narrow_init_level, demod_mode, demod_edge;
    logic [1:0] tx_out_mode;
    logic port3_bit1, port2_bit0, port3_bit6;
    logic [7:0] eight_ctrl_q, sixteen_ctrl_q, n_exp, w_exp;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h00014a69;
    logic [31:0] v;
    logic [7:0] d;
    int edge_cnt = 0;
    int err_total = 0;
    int cmp_count = 0;

    always #12.5 clk = ~clk;

    tpc_ctrl u_tpc_ctrl (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .narrow_timer_output(n_out),
        .wide_timer_output(w_out), .eight_bit_timer_ctrl(eight_ctrl_q),
        .sixteen_bit_timer_ctrl(sixteen_ctrl_q),
        .wide_init_level(wide_init_level),
        .narrow_init_level(narrow_init_level), .tx_out_mode(tx_out_mode),
        .demod_mode(demod_mode), .demod_edge(demod_edge),
        .port3_bit6_data(port3_bit6_data), .port3_bit1(port3_bit1),
        .port2_bit0(port2_bit0),
        .port3_bit6(port3_bit6)
    );

    tpc_pin_src u_tpc_pin_src (
        .clk(clk), .port3_bit1(port3_bit1), .port2_bit0(port2_bit0)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= x;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // expected read data noted at request time
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // read data stands in the cycle after the strobe
    always @(posedge clk)
    begin
        rd_d <= reg_rd;
        if (rd_d)
            chk(reg_rdata, exp_q.pop_front());
        if (demod_edge === 1'b1)
            edge_cnt <= edge_cnt + 1;
    end

    // demod case: clear flags, pulse, read flags, count edge pulses
    task automatic dm(input logic [5:0] c, input logic pin, input int w,
                      input logic [1:0] f);
        int n0;
        wr(2'h1, {2'b11, c});
        n0 = edge_cnt;
        u_tpc_pin_src.pulse(pin, w);
        repeat (24) @(posedge clk);
        rd(2'h1, {f, c});
        chk(8'(edge_cnt - n0), 8'(f[0]) + 8'(f[1]));
    endtask

    function automatic logic comb(input int lg, input logic n, input logic w);
        case (lg)
            0: return n & w;
            1: return n | w;
            2: return ~(n | w);
            default: return ~(n & w);
        endcase
    endfunction

    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(2'h1, 8'h00);
        port3_bit6_data <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h00, port3_bit6}, 8'h01);
        $display("test reset finished");
        for (int i = 0; i < 4; i++)
        begin
            v = rnd();
            d = v[7:0] & 8'hfe;
            wr(i[1:0], d);
            rd(i[1:0], (i == 3) ? 8'h00 : d);
            if (i == 0)
                n_exp = d;
            if (i == 2)
                w_exp = d;
        end
        chk(eight_ctrl_q, n_exp);
        chk(sixteen_ctrl_q, w_exp);
        $display("test register access finished");
        for (int m = 0; m < 4; m++)
        begin
            d = {m[1:0], m[1:0], m[1:0], 2'h2};
            wr(2'h1, d);
            rd(2'h1, d);
            chk({wide_init_level, narrow_init_level, tx_out_mode, 4'h0},
                {d[7:4], 4'h0});
        end
        for (int lg = 0; lg < 4; lg++)
        begin
            wr(2'h1, {4'h0, lg[1:0], 2'h2});
            for (int k = 0; k < 4; k++)
            begin
                v = rnd();
                n_out <= v[0];
                w_out <= v[1];
                port3_bit6_data <= v[2];
                repeat (3) @(posedge clk);
                d = {7'h00, comb(lg, v[0], v[1])};
                chk({7'h00, port3_bit6}, d);
            end
        end
        $display("test transmit finished");
        n_out <= 1'b0;
        w_out <= 1'b0;
        wr(2'h1, 8'h09);
        @(posedge clk);
        chk({7'h00, demod_mode}, 8'h01);
        dm(6'h09, 1'b0, 10, 2'b11);
        wr(2'h1, 8'h89);
        rd(2'h1, 8'h49);
        wr(2'h1, 8'h49);
        rd(2'h1, 8'h09);
        dm(6'h01, 1'b0, 10, 2'b10);
        dm(6'h05, 1'b0, 10, 2'b01);
        dm(6'h19, 1'b0, 3, 2'b00);
        dm(6'h19, 1'b0, 5, 2'b11);
        dm(6'h29, 1'b0, 7, 2'b00);
        dm(6'h29, 1'b0, 9, 2'b11);
        dm(6'h09, 1'b1, 10, 2'b00);
        dm(6'h0b, 1'b1, 10, 2'b11);
        dm(6'h0b, 1'b0, 10, 2'b00);
        $display("test demodulation finished");
        wr(2'h1, 8'h00);
        @(posedge clk);
        chk({7'h00, demod_mode}, 8'h00);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(2'h1, 8'h00);
        rd(2'h0, 8'h00);
        repeat (4) @(posedge clk);
        chk(sixteen_ctrl_q, 8'h00);
        $display("test second reset finished");
        conclude();
    end

    initial
    begin
        #(25 * 5000);
        err_total++;
        conclude();
    end
endmodule
